// ---- rtl/servo_io_pkg.sv ----
package servo_io_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_MAP_MON  = 8'h04;
  localparam logic [7:0] OFF_MAP_EXT  = 8'h08;
  localparam logic [7:0] OFF_POLARITY = 8'h0C;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int MON_COUNT   = 5;
  localparam int ROUTE_COUNT = 6;   // five monitor inputs and the servo enable
  localparam int CHAN_COUNT  = 8;
  localparam int CODE_W      = 4;   // 0 = unassigned, 1..8 = input channel
  localparam int EXT_ROUTE   = 5;   // route slot of the servo enable input
  localparam int CTRL_NET_SON   = 0;
  localparam int CTRL_SETUP_SON = 1;
  localparam int ST_EXT_EN   = 5;
  localparam int ST_SERVO_ON = 6;
  localparam int ST_READY    = 7;
  localparam int ST_FAULT    = 8;
  localparam int ST_BRAKE    = 9;
  localparam int EV_COUNT    = 8;
  localparam int EV_EXT      = 5;
  localparam int EV_RDY_LOST = 6;
  localparam int EV_ALARM    = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // monitor 1 -> ch4, 2 and 3 unassigned, 4 -> ch8, 5 -> ch1
  localparam logic [31:0] RST_MAP_MON  = 32'h0001_8004;
  localparam logic [31:0] RST_MAP_EXT  = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_POLARITY = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;

  // picks one input channel by its code; unassigned or illegal reads as off
  function automatic logic chanPick(input logic [CHAN_COUNT:1] chan, input logic [CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    if ((code != 4'h0) && (code <= 4'h8))
    begin
      hit = chan[code];
    end
    return hit;
  endfunction

endpackage

// ---- rtl/io_route_if.sv ----
`timescale 1ns/10ps
interface io_route_if;
  import servo_io_pkg::*;

  logic [CHAN_COUNT:1]              chan;
  logic [ROUTE_COUNT*CODE_W-1:0]    mapCodes;
  logic [ROUTE_COUNT-1:0]           routed;
  logic [ROUTE_COUNT-1:0]           assigned;

  modport router
  (
    input  chan,
    input  mapCodes,
    output routed,
    output assigned
  );

  modport owner
  (
    output chan,
    output mapCodes,
    input  routed,
    input  assigned
  );
endinterface

// ---- rtl/input_router.sv ----
`timescale 1ns/10ps
module input_router
  import servo_io_pkg::*;
(
  // channel selection
  io_route_if.router rt
);

  // ----------------------------------------------------------------
  // one selector per logical input
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ROUTE_COUNT; i++)
    begin : g_route
      wire [CODE_W-1:0] code = rt.mapCodes[i*CODE_W +: CODE_W];
      // any channel may feed any input; a zero code leaves it unassigned
      assign rt.routed[i]   = chanPick(rt.chan, code);
      assign rt.assigned[i] = (code != 4'h0) && (code <= 4'h8);
    end
  endgenerate

endmodule

// ---- rtl/servo_drive_io.sv ----
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
module servo_drive_io
  import servo_io_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // field input channels
  input  wire logic [CHAN_COUNT:1]  inputChan,
  // drive state
  input  wire logic                 powerOk,
  input  wire logic                 alarmActive,
  input  wire logic                 netSyncOk,
  input  wire logic                 brakeReleaseReq,
  input  wire logic                 netServoOnCmd,
  // drive control and network response
  output logic                      servoOnCmd,
  output logic [MON_COUNT-1:0]      monitorResp,
  // discrete outputs
  output logic                      faultStatusOut,
  output logic                      driveReadyOut,
  output logic                      brakeReleaseOut,
  // interrupt
  output logic                      irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;
  wire  rstN = rstSync_reg;

  // release is synchronised so no flop leaves reset on a split edge
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]                ctrl_reg;
  logic [31:0]                mapMon_reg;
  logic [31:0]                mapExt_reg;
  logic [31:0]                polarity_reg;
  logic [EV_COUNT-1:0]        irqStat_reg;
  logic [EV_COUNT-1:0]        irqMask_reg;
  logic [ROUTE_COUNT-1:0]     routed_reg;
  logic                       ready_reg;
  logic                       alarm_reg;
  logic                       pready_reg;
  logic [31:0]                prdata_reg;
  logic                       pslverr_reg;
  logic                       servoOn_reg;
  logic                       fault_reg;
  logic                       brake_reg;
  logic                       irq_reg;
  logic [ROUTE_COUNT-1:0]     routed_next;
  logic [EV_COUNT-1:0]        irqStat_next;

  // ----------------------------------------------------------------
  // input routing
  // ----------------------------------------------------------------
  io_route_if routeBus ();

  // the servo enable shares the selector with the monitor inputs
  assign routeBus.chan     = inputChan;
  assign routeBus.mapCodes = {mapExt_reg[CODE_W-1:0], mapMon_reg[MON_COUNT*CODE_W-1:0]};

  input_router u_router
  (
    .rt (routeBus.router)
  );

  // polarity flips a contact to break-type; an unassigned servo enable reads as on
  wire [ROUTE_COUNT-1:0] polarised = routeBus.routed ^ polarity_reg[ROUTE_COUNT-1:0];
  wire                   extEnRaw  = routeBus.assigned[EXT_ROUTE] ? polarised[EXT_ROUTE] : 1'b1;
  wire [MON_COUNT-1:0]   monLevel  = polarised[MON_COUNT-1:0] & routeBus.assigned[MON_COUNT-1:0];

  assign routed_next = {extEnRaw, monLevel};

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      // an unassigned servo enable idles on; resetting to that level keeps a false change event away
      routed_reg <= {1'b1, {MON_COUNT{1'b0}}};
    end
    else
    begin
      routed_reg <= routed_next;
    end
  end

  // ----------------------------------------------------------------
  // drive control logic
  // ----------------------------------------------------------------
  // monitor levels go to the response word, the status word and the change events, never into the terms below
  wire extEnable   = routed_reg[EXT_ROUTE];
  wire anyServoOn  = netServoOnCmd | ctrl_reg[CTRL_NET_SON] | ctrl_reg[CTRL_SETUP_SON];
  wire servoOnNext = extEnable & anyServoOn;
  wire readyNext   = powerOk & ~alarmActive & netSyncOk;

  // servo-on command is re-evaluated every edge, so a dropped enable stops it at once
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      servoOn_reg <= 1'b0;
    end
    else
    begin
      servoOn_reg <= servoOnNext;
    end
  end

  // ready follows its terms each edge, so it never latches
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= readyNext;
    end
  end

  // fault output is on in normal status; the alarm copy feeds the entry event
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      fault_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end
    else
    begin
      fault_reg <= ~alarmActive;
      alarm_reg <= alarmActive;
    end
  end

  // brake stays engaged in reset, the safe state for a held axis
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      brake_reg <= 1'b0;
    end
    else
    begin
      brake_reg <= brakeReleaseReq;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setupPhase = psel & ~penable;
  wire writeDone  = psel & penable & pready_reg & pwrite;
  wire hitCtrl    = (paddr == OFF_CTRL);
  wire hitMapMon  = (paddr == OFF_MAP_MON);
  wire hitMapExt  = (paddr == OFF_MAP_EXT);
  wire hitPol     = (paddr == OFF_POLARITY);
  wire hitStatus  = (paddr == OFF_STATUS);
  wire hitIrqStat = (paddr == OFF_IRQ_STAT);
  wire hitIrqMask = (paddr == OFF_IRQ_MASK);
  wire mapped     = hitCtrl | hitMapMon | hitMapExt | hitPol | hitStatus | hitIrqStat | hitIrqMask;

  // status word reflects the block's own state
  wire [31:0] statusWord = {22'h00_0000, brake_reg, fault_reg, ready_reg, servoOn_reg, routed_reg};

  wire [31:0] readMux =
    hitCtrl    ? ctrl_reg :
    hitMapMon  ? mapMon_reg :
    hitMapExt  ? mapExt_reg :
    hitPol     ? polarity_reg :
    hitStatus  ? statusWord :
    hitIrqStat ? {24'h00_0000, irqStat_reg} :
    hitIrqMask ? {24'h00_0000, irqMask_reg} :
    32'h0000_0000;

  // answer is prepared in the setup cycle so the access phase ends at once
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setupPhase;
      prdata_reg  <= (setupPhase && !pwrite) ? readMux : 32'h0000_0000;
      pslverr_reg <= setupPhase & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // write strobes; unmapped writes hit none of them and are flagged through pslverr only
  wire wrCtrl    = writeDone & hitCtrl;
  wire wrMapMon  = writeDone & hitMapMon;
  wire wrMapExt  = writeDone & hitMapExt;
  wire wrPol     = writeDone & hitPol;
  wire wrIrqMask = writeDone & hitIrqMask;

  // only the two command bits exist; the rest read back as zero
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_reg <= RST_CTRL;
    end
    else if (wrCtrl)
    begin
      ctrl_reg <= {30'h0000_0000, pwdata[CTRL_SETUP_SON], pwdata[CTRL_NET_SON]};
    end
  end

  // monitor map; its reset value is the default channel assignment
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mapMon_reg <= RST_MAP_MON;
    end
    else if (wrMapMon)
    begin
      mapMon_reg <= {12'h000, pwdata[MON_COUNT*CODE_W-1:0]};
    end
  end

  // servo enable map starts at zero, so the input stays unassigned until software routes it
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mapExt_reg <= RST_MAP_EXT;
    end
    else if (wrMapExt)
    begin
      mapExt_reg <= {28'h000_0000, pwdata[CODE_W-1:0]};
    end
  end

  // contact polarity per routed input
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      polarity_reg <= RST_POLARITY;
    end
    else if (wrPol)
    begin
      polarity_reg <= {26'h000_0000, pwdata[ROUTE_COUNT-1:0]};
    end
  end

  // interrupt mask, same layout as the status bits
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      irqMask_reg <= RST_IRQ_MASK[EV_COUNT-1:0];
    end
    else if (wrIrqMask)
    begin
      irqMask_reg <= pwdata[EV_COUNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  // changes compare the registered levels with the unregistered next levels from the router, so an event sets at the edge the level is taken
  wire [ROUTE_COUNT-1:0] inputChange = routed_reg ^ routed_next;
  wire                   readyLost   = ready_reg & ~readyNext;
  wire                   alarmRise   = alarmActive & ~alarm_reg;
  wire [EV_COUNT-1:0]    eventSet    = {alarmRise, readyLost, inputChange};
  wire [EV_COUNT-1:0]    clearMask   = (writeDone && hitIrqStat) ? pwdata[EV_COUNT-1:0] : 8'h00;

  // a new event in the clearing cycle survives the clear
  assign irqStat_next = (irqStat_reg & ~clearMask) | eventSet;

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      irqStat_reg <= 8'h00;
    end
    else
    begin
      irqStat_reg <= irqStat_next;
    end
  end

  // taken from the next status, so irq rises at the same edge as its status bit
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(irqStat_next & irqMask_reg);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready          = pready_reg;
  assign prdata          = prdata_reg;
  assign pslverr         = pslverr_reg;
  assign servoOnCmd      = servoOn_reg;
  assign monitorResp     = routed_reg[MON_COUNT-1:0];
  assign faultStatusOut  = fault_reg;
  assign driveReadyOut   = ready_reg;
  assign brakeReleaseOut = brake_reg;
  assign irq             = irq_reg;

endmodule

// ---- test/servo_io_assertions.sv ----
`timescale 1ns/10ps
module servo_io_checker
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // drive state and outputs
  input wire logic powerOk,
  input wire logic alarmActive,
  input wire logic netSyncOk,
  input wire logic brakeReleaseReq,
  input wire logic faultStatusOut,
  input wire logic driveReadyOut,
  input wire logic brakeReleaseOut
);
  logic [2:0] upCnt;
  logic       up;

  // outputs track inputs only once the reset synchroniser has let go
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      upCnt <= 3'h0;
    else if (upCnt != 3'h5)
      upCnt <= upCnt + 3'h1;
  assign up = (upCnt >= 3'h4);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  fault_follows_alarm_a: assert property (up |-> faultStatusOut == !$past(alarmActive))
    else $error("fault output does not follow alarm");
  ready_all_conds_a: assert property (up |-> driveReadyOut == $past(powerOk && !alarmActive && netSyncOk))
    else $error("ready output wrong");
  ready_drops_fast_a: assert property (up && ($fell(powerOk) || $rose(alarmActive) || $fell(netSyncOk))
    |=> !driveReadyOut)
    else $error("ready output held after a condition was lost");
  brake_follows_req_a: assert property (up |-> brakeReleaseOut == $past(brakeReleaseReq))
    else $error("brake output wrong");
  alarm_blocks_ready_a: assert property (up && !faultStatusOut |-> !driveReadyOut)
    else $error("ready while in alarm");
  apb_zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_pulse_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

bind servo_drive_io servo_io_checker chk_i (.core_clk, .rst_b, .psel, .penable, .pready, .pslverr, .powerOk,
  .alarmActive, .netSyncOk, .brakeReleaseReq, .faultStatusOut, .driveReadyOut, .brakeReleaseOut);

// ---- test/field_side_model.sv ----
`timescale 1ns/10ps
module field_side_model
  import servo_io_pkg::*;
(
  // sensor contacts
  input  wire logic                core_clk,
  input  wire logic [CHAN_COUNT:1] fieldLevels,
  output logic      [CHAN_COUNT:1] inputChan,
  // brake relay
  input  wire logic                brakeReleaseOut,
  output logic                     brakeEngaged
);
  // contacts reach the connector one clock late, as field wiring would
  always_ff @(posedge core_clk)
    inputChan <= fieldLevels;
  // the relay coil sits on a fixed pin whatever the control mode
  assign brakeEngaged = !brakeReleaseOut;
endmodule

// ---- test/tb_servo_drive_io.sv ----
`timescale 1ns/10ps
module tb_servo_drive_io
  import servo_io_pkg::*;
;
  localparam logic [31:0] zeroWord = 32'h0000_0000;
  logic                  core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = zeroWord, rd, mapv, seed = 32'h0000_005B;
  logic [CHAN_COUNT:1]   fieldLevels = 8'h00, inputChan;
  logic                  powerOk = 1'b0, alarmActive = 1'b0, netSyncOk = 1'b0;
  logic                  brakeReleaseReq = 1'b0, netServoOnCmd = 1'b0, err;
  logic                  pready, pslverr, servoOnCmd, faultStatusOut, driveReadyOut, brakeReleaseOut, irq;
  logic                  brakeEngaged;
  logic [31:0]           prdata;
  logic [MON_COUNT-1:0]  monitorResp;
  int                    err_total = 0, checks_done = 0;

  always #10 core_clk = ~core_clk;

  servo_drive_io servo_drive_io_i (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .inputChan, .powerOk, .alarmActive, .netSyncOk, .brakeReleaseReq, .netServoOnCmd,
    .servoOnCmd, .monitorResp, .faultStatusOut, .driveReadyOut, .brakeReleaseOut, .irq);
  field_side_model field_side_model_i (.core_clk, .fieldLevels, .inputChan, .brakeReleaseOut, .brakeEngaged);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  // unassigned and out-of-range codes read as off
  function automatic logic [4:0] monExp(input logic [8:1] c, input logic [31:0] m);
    logic [4:0] r;
    logic [3:0] k;
    for (int i = 0; i < 5; i++)
    begin
      k = m[i*4 +: 4];
      r[i] = (k >= 4'h1 && k <= 4'h8) ? c[k] : 1'b0;
    end
    return r;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high at a rising edge, or for at most 20 access edges
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang costs a mismatch and ends the run through the same door
  initial
  begin
    #100000;
    err_total++;
    report_and_stop;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    apb(1'b0, OFF_MAP_MON, zeroWord);
    chk("map_mon", rd, RST_MAP_MON);
    apb(1'b0, OFF_MAP_EXT, zeroWord);
    chk("map_ext", rd, RST_MAP_EXT);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, zeroWord);
    chk("slverr", {31'h0000_0000, err}, 32'h0000_0001);
    chk("unmapped", rd, zeroWord);
    mapv = RST_MAP_MON;
    // random field and drive state; later rounds remap the monitors too
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      if (i >= 8)
      begin
        mapv = {12'h000, seed[19:0]};
        apb(1'b1, OFF_MAP_MON, mapv);
        apb(1'b0, OFF_MAP_MON, zeroWord);
        chk("map_back", rd, mapv);
      end
      @(posedge core_clk);
      fieldLevels <= seed[31:24];
      {powerOk, alarmActive, netSyncOk, brakeReleaseReq} <= seed[23:20];
      settle;
      chk("monitor", monitorResp, monExp(fieldLevels, mapv));
      chk("servo_on_idle", servoOnCmd, 0);
      chk("fault", faultStatusOut, !alarmActive);
      chk("ready", driveReadyOut, powerOk && !alarmActive && netSyncOk);
      chk("brake", brakeReleaseOut, brakeReleaseReq);
      chk("brake_relay", brakeEngaged, !brakeReleaseReq);
    end
    // servo enable on channel 2, every mix of enable, the netServoOnCmd pin and both control register command bits
    apb(1'b1, OFF_MAP_EXT, 32'h0000_0002);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, OFF_CTRL, {30'h0000_0000, i[3:2]});
      @(posedge core_clk);
      fieldLevels[2] <= i[0];
      netServoOnCmd <= i[1];
      settle;
      chk("servo_on", servoOnCmd, i[0] && (i[1] || i[2] || i[3]));
    end
    // polarity turns the servo enable into a break contact; enable pin is high, commands on
    apb(1'b1, OFF_POLARITY, 32'h0000_0020);
    settle;
    chk("servo_pol_hi", servoOnCmd, 1'b0);
    @(posedge core_clk);
    fieldLevels[2] <= 1'b0;
    settle;
    chk("servo_pol_lo", servoOnCmd, 1'b1);
    apb(1'b0, OFF_STATUS, zeroWord);
    chk("status_son", rd[ST_SERVO_ON], 1'b1);
    chk("status_err", {31'h0000_0000, err}, zeroWord);
    apb(1'b1, OFF_POLARITY, zeroWord);
    // alarm event: raise, mask, clear
    @(posedge core_clk);
    alarmActive <= 1'b0;
    settle;
    apb(1'b1, OFF_IRQ_STAT, 32'hFFFF_FFFF);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0080);
    @(posedge core_clk);
    alarmActive <= 1'b1;
    settle;
    chk("irq_set", irq, 1'b1);
    chk("fault_alarm", faultStatusOut, 1'b0);
    apb(1'b0, OFF_IRQ_STAT, zeroWord);
    chk("alarm_event", rd[EV_ALARM], 1'b1);
    apb(1'b1, OFF_IRQ_MASK, zeroWord);
    settle;
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0080);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_0080);
    settle;
    chk("irq_clear", irq, 1'b0);
    apb(1'b0, OFF_IRQ_STAT, zeroWord);
    chk("alarm_cleared", rd[EV_ALARM], 1'b0);
    // alarm enters at the very edge its bit is cleared: the new event must survive
    @(posedge core_clk);
    alarmActive <= 1'b0;
    settle;
    fork
      apb(1'b1, OFF_IRQ_STAT, 32'h0000_0080);
      begin
        repeat (2) @(posedge core_clk);
        alarmActive <= 1'b1;
      end
    join
    apb(1'b0, OFF_IRQ_STAT, zeroWord);
    chk("set_wins", rd[EV_ALARM], 1'b1);
    // second reset mid-run: the monitor map returns to default and the release invents no event
    @(posedge core_clk);
    fieldLevels <= 8'h00;
    alarmActive <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    apb(1'b0, OFF_MAP_MON, zeroWord);
    chk("map_mon_rst", rd, RST_MAP_MON);
    apb(1'b0, OFF_IRQ_STAT, zeroWord);
    chk("irq_stat_rst", rd, zeroWord);
    report_and_stop;
  end
endmodule
